// ==== design/rsec_top.sv ====
/*
 * Reset pin sequencing, low-power exit and evaluation-mode bus control.
 * An outside fall of the pin is seen through two synchroniser stages,
 * so the stretch starts a few edges after the pin goes low.
 * Assumes an external pull-up on the open-drain reset wire and that the
 * processor signals the end of each machine cycle with a one-cycle pulse.
 */
`timescale 1ns/1ns
`default_nettype none

module rsec_top
    import rsec_pkg::*;
#(
    parameter logic [POR_CNT_W-1:0] POR_CYCLES = POR_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic rst,
    // Open-drain reset pin
    input wire logic reset_pin_in,
    output var logic reset_pin_out,
    output var logic reset_pin_oe,
    input wire logic reset_out_disable,
    output var logic sys_reset,
    // Low-power control
    input wire logic stop_req,
    input wire logic idle_req,
    output var logic [1:0] lp_mode,
    // Evaluation mode
    input wire logic evaluation_select,
    input wire logic bus_request_n,
    input wire logic machine_cycle_end,
    output var logic eval_mode,
    output var logic ctl_pins_oe,
    output var logic cpu_detached,
    output var logic bus_pins_oe,
    output var logic data_bus_reverse,
    output var logic bus_grant_oe
);

    // ====================================================================
    // State
    // ====================================================================
    typedef struct packed {
        rsec_phase_t phase;
        logic [POR_CNT_W-1:0] por_cnt;
        logic [STRETCH_CNT_W-1:0] str_cnt;
        logic pin_prev;
        logic pin_oe;
        logic sys_rst;
        rsec_lp_t lp;
        logic eval;
        logic ctl_oe;
        logic detached;
        logic data_rev;
        logic bus_oe;
        logic grant_oe;
    } rsec_state_t;

    // Power-on state: pin pulled low, core held in reset
    localparam rsec_state_t STATE_RESET = '{
        phase: RSEC_PH_POR,
        por_cnt: '0,
        str_cnt: '0,
        pin_prev: PIN_IDLE,
        pin_oe: FLAG_ON,
        sys_rst: FLAG_ON,
        lp: RSEC_LP_RUN,
        eval: FLAG_OFF,
        ctl_oe: FLAG_ON,
        detached: FLAG_OFF,
        data_rev: FLAG_OFF,
        bus_oe: FLAG_ON,
        grant_oe: FLAG_ON
    };

    rsec_state_t state_reg;
    rsec_state_t state_next;
    // Synchronised pin and its falling edge
    logic pin_sync;
    logic pin_fall;

    // ====================================================================
    // Reset pin synchroniser
    // ====================================================================
    rsec_sync #(
        .RESET_VAL(PIN_IDLE)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d(reset_pin_in),
        .q(pin_sync)
    );

    // Falling edge of the synchronised pin
    assign pin_fall = state_reg.pin_prev & ~pin_sync;

    // ====================================================================
    // Next-state logic
    // ====================================================================
    always_comb begin
        state_next = state_reg;
        state_next.pin_prev = pin_sync;

        // Reset pin sequencer
        case (state_reg.phase)
            RSEC_PH_POR: begin
                // Hold the pin low for the power-up interval
                if (state_reg.por_cnt == POR_CYCLES - POR_CNT_W'(1)) begin
                    state_next.phase = RSEC_PH_RUN;
                    state_next.por_cnt = '0;
                end else begin
                    state_next.por_cnt = state_reg.por_cnt + POR_CNT_W'(1);
                end
            end
            RSEC_PH_RUN: begin
                // Stretch an external reset unless stretching is disabled
                // Falls from our own drive land in POR or STRETCH and are ignored
                if (pin_fall && !reset_out_disable) begin
                    state_next.phase = RSEC_PH_STRETCH;
                    state_next.str_cnt = '0;
                end
            end
            RSEC_PH_STRETCH: begin
                // Sixteen edges with the pin held low
                if (state_reg.str_cnt == STRETCH_CYCLES - STRETCH_CNT_W'(1)) begin
                    state_next.phase = RSEC_PH_RUN;
                    state_next.str_cnt = '0;
                end else begin
                    state_next.str_cnt = state_reg.str_cnt + STRETCH_CNT_W'(1);
                end
            end
            default: begin
                // Unused code releases the pin
                state_next.phase = RSEC_PH_RUN;
            end
        endcase

        // Drive the pin low in every phase but RUN
        state_next.pin_oe = (state_next.phase != RSEC_PH_RUN);

        // Internal reset follows our drive or an external low level
        // Our own drive reads back through the synchroniser, so the
        // internal reset outlasts the pin by three edges
        state_next.sys_rst = state_next.pin_oe | ~pin_sync;

        // Low-power state: reset always returns to running
        // A request in the same cycle as a reset is dropped
        if (state_next.sys_rst) begin
            state_next.lp = RSEC_LP_RUN;
        end else begin
            case (state_reg.lp)
                RSEC_LP_RUN: begin
                    if (stop_req) begin
                        state_next.lp = RSEC_LP_STOP;
                    end else if (idle_req) begin
                        state_next.lp = RSEC_LP_IDLE;
                    end
                end
                RSEC_LP_STOP: begin
                    // Only a reset wakes the core
                    state_next.lp = RSEC_LP_STOP;
                end
                RSEC_LP_IDLE: begin
                    // Only a reset wakes the core
                    state_next.lp = RSEC_LP_IDLE;
                end
                default: begin
                    // Unused code wakes the core
                    state_next.lp = RSEC_LP_RUN;
                end
            endcase
        end

        // Evaluation mode follows the select input
        state_next.eval = evaluation_select;

        // Fetch, halt and refresh pins turn to inputs in evaluation mode
        state_next.ctl_oe = ~evaluation_select;

        // Detach from the bus once the current machine cycle finishes
        // Reset cancels a pending hand-over so the core starts on the bus
        if (!evaluation_select || bus_request_n || state_next.sys_rst) begin
            state_next.detached = FLAG_OFF;
        end else if (machine_cycle_end) begin
            state_next.detached = FLAG_ON;
        end

        // Address and strobes turn to inputs, data turns round, while detached
        state_next.bus_oe = ~state_next.detached;
        state_next.data_rev = state_next.detached;

        // Bus grant keeps driving; isolation is left to the board
        state_next.grant_oe = FLAG_ON;
    end

    // ====================================================================
    // State register
    // ====================================================================
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ====================================================================
    // Outputs straight from the state register, except the fixed-low pin data
    // ====================================================================
    // Open-drain data is fixed low; only the enable moves
    assign reset_pin_out = PIN_LOW;
    assign reset_pin_oe = state_reg.pin_oe;
    assign sys_reset = state_reg.sys_rst;
    assign lp_mode = state_reg.lp;
    assign eval_mode = state_reg.eval;
    assign ctl_pins_oe = state_reg.ctl_oe;
    assign cpu_detached = state_reg.detached;
    assign bus_pins_oe = state_reg.bus_oe;
    assign data_bus_reverse = state_reg.data_rev;
    assign bus_grant_oe = state_reg.grant_oe;

endmodule : rsec_top

`default_nettype wire

// ==== design/rsec_pkg.sv ====
/*
 * Constants and types shared by the reset and evaluation control block.
 * Assumes a single 250 MHz processor clock and an asynchronous power-on reset.
 */
// Behaviour
// - Power-up: pull reset pin low 25-75 ms
// - External reset: drive pin low 16 cycles
// - Reset initialises processor and peripheral logic
// - Reset ends STOP or IDLE low-power states
// - Evaluation mode: fetch, halt, refresh pins input
// - Eval plus bus request: detach after cycle
// - Then address, strobes input, data reversed
// - Stretch only when disable is zero, from fall
package rsec_pkg;

    // ====================================================================
    // Timing
    // ====================================================================
    localparam int CLK_KHZ = 250_000;
    localparam int POR_MIN_MS = 25;
    localparam int POR_MAX_MS = 75;
    localparam int POR_CNT_W = 24;
    // Least time in cycles, rounded up to a whole number of milliseconds
    localparam logic [POR_CNT_W-1:0] POR_CYCLES_DEF =
        POR_CNT_W'((POR_MIN_MS * CLK_KHZ + CLK_KHZ - 1) / CLK_KHZ * CLK_KHZ);
    localparam int STRETCH_CNT_W = 5;
    localparam logic [STRETCH_CNT_W-1:0] STRETCH_CYCLES = 5'h10;

    // ====================================================================
    // Reset values of pins and flags
    // ====================================================================
    localparam logic PIN_IDLE = 1'b1;
    localparam logic PIN_LOW = 1'b0;
    localparam logic FLAG_OFF = 1'b0;
    localparam logic FLAG_ON = 1'b1;

    // ====================================================================
    // State encodings
    // ====================================================================
    typedef enum logic [1:0] {
        RSEC_PH_POR = 2'b00,
        RSEC_PH_RUN = 2'b01,
        RSEC_PH_STRETCH = 2'b10
    } rsec_phase_t;

    typedef enum logic [1:0] {
        RSEC_LP_RUN = 2'b00,
        RSEC_LP_STOP = 2'b01,
        RSEC_LP_IDLE = 2'b10
    } rsec_lp_t;

endpackage : rsec_pkg

// ==== design/rsec_sync.sv ====
/*
 * Two-flop level synchroniser.
 * Assumes the input may change at any time relative to clk_sys.
 */
`timescale 1ns/1ns
`default_nettype none

module rsec_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic d,
    output var logic q
);

    logic meta_reg;

    // ====================================================================
    // Synchroniser chain
    // ====================================================================
    // First stage is read only by the second
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_reg <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule : rsec_sync

`default_nettype wire

// ==== test/rsec_sva.sv ====
/*
 * Port assertions for the reset and evaluation control block.
 * Assumes it is bound to each rsec_top instance, one clock domain.
 */
`timescale 1ns/1ns
`default_nettype none

module rsec_sva
    import rsec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reset_pin_in,
    input wire logic reset_pin_oe,
    input wire logic reset_out_disable,
    input wire logic sys_reset,
    input wire logic stop_req,
    input wire logic idle_req,
    input wire logic [1:0] lp_mode,
    input wire logic evaluation_select,
    input wire logic bus_request_n,
    input wire logic machine_cycle_end,
    input wire logic eval_mode,
    input wire logic ctl_pins_oe,
    input wire logic cpu_detached,
    input wire logic bus_pins_oe,
    input wire logic data_bus_reverse,
    input wire logic bus_grant_oe
);
    // ====================================================================
    // Reset pin, low power and bus hand-over
    // ====================================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_stretch;
        $rose(reset_pin_oe) |-> reset_pin_oe[*8] ##1 reset_pin_oe[*8] ##1 !reset_pin_oe;
    endproperty
    a_stretch: assert property (p_stretch) else $error("stretch length wrong");
    property p_gate;
        $rose(reset_pin_oe) |-> !$past(reset_out_disable);
    endproperty
    a_gate: assert property (p_gate) else $error("stretch while disabled");
    property p_cover;
        reset_pin_oe |-> sys_reset;
    endproperty
    a_cover: assert property (p_cover) else $error("pin driven without reset");
    property p_pin;
        !reset_pin_in[*3] |-> ##[0:2] sys_reset;
    endproperty
    a_pin: assert property (p_pin) else $error("low pin gave no reset");
    property p_lp_exit;
        sys_reset |-> lp_mode == RSEC_LP_RUN;
    endproperty
    a_lp_exit: assert property (p_lp_exit) else $error("low power kept in reset");
    property p_stop;
        stop_req && lp_mode == RSEC_LP_RUN ##1 !sys_reset |-> lp_mode == RSEC_LP_STOP;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not entered");
    property p_idle;
        idle_req && !stop_req && lp_mode == RSEC_LP_RUN ##1 !sys_reset |-> lp_mode == RSEC_LP_IDLE;
    endproperty
    a_idle: assert property (p_idle) else $error("idle not entered");
    property p_eval;
        evaluation_select |=> eval_mode && !ctl_pins_oe;
    endproperty
    a_eval: assert property (p_eval) else $error("control pins not inputs");
    property p_ctl;
        !evaluation_select |=> !eval_mode && ctl_pins_oe && bus_grant_oe;
    endproperty
    a_ctl: assert property (p_ctl) else $error("control pins not driven");
    property p_detach;
        evaluation_select && !bus_request_n && machine_cycle_end && eval_mode ##1 !sys_reset
            |-> cpu_detached && !bus_pins_oe && data_bus_reverse;
    endproperty
    a_detach: assert property (p_detach) else $error("no detach");
    property p_attach;
        cpu_detached && bus_request_n |=> !cpu_detached && bus_pins_oe;
    endproperty
    a_attach: assert property (p_attach) else $error("no reattach");
endmodule : rsec_sva

bind rsec_top rsec_sva u_sva (.clk_sys, .rst, .reset_pin_in, .reset_pin_oe,
    .reset_out_disable, .sys_reset, .stop_req, .idle_req, .lp_mode, .evaluation_select,
    .bus_request_n, .machine_cycle_end, .eval_mode, .ctl_pins_oe, .cpu_detached,
    .bus_pins_oe, .data_bus_reverse, .bus_grant_oe);

`default_nettype wire

// ==== test/rsec_board.sv ====
/*
 * Board reset circuit: open-drain press button on a pulled-up wire.
 * Assumes the device pulls the same wire through its own enable.
 */
`timescale 1ns/1ns
`default_nettype none

module rsec_board #(
    parameter int HOLD = 3
) (
    input wire logic clk_sys,
    input wire logic press,
    input wire logic dut_oe,
    input wire logic dut_out,
    output var logic pin
);
    // ====================================================================
    // Press holds the wire low for HOLD cycles
    // ====================================================================
    int cnt = 0;
    always @(posedge clk_sys) begin
        if (press) cnt <= HOLD;
        else if (cnt > 0) cnt <= cnt - 1;
    end
    // Pull-up wins unless someone drives low
    assign pin = !((dut_oe && !dut_out) || cnt > 0);
endmodule : rsec_board

`default_nettype wire

// ==== test/tb.sv ====
/*
 * Self-checking bench for rsec_top with a short power-up count.
 * Assumes the board model and the bound checker are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

module tb;
    import rsec_pkg::*;
    // ====================================================================
    // Stimulus, model and checks
    // ====================================================================
    localparam logic [POR_CNT_W-1:0] POR = 24'h00_0014;
    logic clk_sys = 0, rst = 1, press = 0, dis = 0, stop_q = 0, idle_q = 0;
    logic ev = 0, brq_n = 1, mce = 0;
    logic pin, pin_d, oe, sres, evm, ctl_oe, det, bus_oe, rev, grant;
    logic [1:0] lp;
    int error_cnt = 0, total_checks = 0, cycles = 0, n;
    rsec_board board (.clk_sys(clk_sys), .press(press), .dut_oe(oe), .dut_out(pin_d),
        .pin(pin));
    rsec_top #(.POR_CYCLES(POR)) dut (.clk_sys(clk_sys), .rst(rst), .reset_pin_in(pin),
        .reset_pin_out(pin_d), .reset_pin_oe(oe), .reset_out_disable(dis), .sys_reset(sres),
        .stop_req(stop_q), .idle_req(idle_q), .lp_mode(lp), .evaluation_select(ev),
        .bus_request_n(brq_n), .machine_cycle_end(mce), .eval_mode(evm),
        .ctl_pins_oe(ctl_oe), .cpu_detached(det), .bus_pins_oe(bus_oe),
        .data_bus_reverse(rev), .bus_grant_oe(grant));
    always #2 clk_sys = ~clk_sys;
    // Cut a hang short
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask : cyc
    task automatic chk(input logic c, input string msg);
        total_checks++;
        if (c !== 1'b1) begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic t_power();
        n = 0;
        while (oe === 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        chk(n == POR || n == POR + 1, "power-up length");
        chk(POR_CYCLES_DEF === 24'h5F_5E10, "power-up default");
        chk(pin_d === 1'b0, "open-drain data not low");
        cyc(3);
        chk(sres === 1'b0 && pin === 1'b1, "reset after power-up");
    endtask : t_power
    task automatic t_stretch();
        press = 1;
        cyc(1);
        press = 0;
        n = 0;
        while (oe !== 1'b1 && n < 10) begin
            cyc(1);
            n++;
        end
        n = 0;
        while (oe === 1'b1 && n < 40) begin
            chk(sres, "reset during stretch");
            cyc(1);
            n++;
        end
        chk(n == 16, "stretch length");
        cyc(3);
        chk(sres === 1'b0, "reset after stretch");
    endtask : t_stretch
    task automatic t_nostretch();
        dis = 1;
        cyc(2);
        press = 1;
        cyc(1);
        press = 0;
        cyc(3);
        chk(sres, "reset follows pin");
        repeat (10) begin
            chk(oe === 1'b0, "stretch while disabled");
            cyc(1);
        end
        chk(sres === 1'b0, "reset released");
        dis = 0;
    endtask : t_nostretch
    task automatic t_lowpower(input logic idle);
        stop_q = !idle;
        idle_q = idle;
        cyc(1);
        {stop_q, idle_q} = 2'b00;
        cyc(1);
        chk(lp === (idle ? RSEC_LP_IDLE : RSEC_LP_STOP), "low power entry");
        t_stretch();
        chk(lp === RSEC_LP_RUN, "low power exit");
    endtask : t_lowpower
    task automatic t_eval();
        ev = 1;
        cyc(2);
        chk(evm && !ctl_oe, "eval pins");
        brq_n = 0;
        cyc(2);
        chk(!det && bus_oe, "detached early");
        mce = 1;
        cyc(1);
        mce = 0;
        cyc(1);
        chk(det && !bus_oe && rev && grant, "detach");
        brq_n = 1;
        cyc(2);
        chk(!det && bus_oe && !rev, "reattach");
        ev = 0;
        cyc(2);
        chk(ctl_oe && !evm, "eval exit");
    endtask : t_eval
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    // Main sequence
    initial begin
        cyc(4);
        rst = 0;
        t_power();
        t_stretch();
        t_nostretch();
        t_lowpower(1'b0);
        t_lowpower(1'b1);
        t_eval();
        finish_test();
    end
endmodule : tb

`default_nettype wire
